// ==== hdl/psar_regs.sv ====
// PHY status, identifier and auto-negotiation register bank
//
// Operation
// - sixteen-bit registers, identical on pages 0-2
// - fixed ability bits in status 15:9
// - status bits 8 and 0 read one
// - status bit 5 shows negotiation done
// - status bit 4 shows remote fault
// - status bit 3 reads one on pages 0-2; the whole register reads zero on higher pages
// - link bit latches low until read
// - status bit 1 shows jabber
// - identifier high holds OUI bits 3-18
// - identifier low 15:10 holds OUI 19-24
// - model number is read-write
// - revision is read-write, reset per silicon
// - next-page bit writable; 14,12,9 reserved
// - local remote-fault bit writable, resets zero
// - pause bits writable, reset zero
// - speed ability bits writable, reset one
// - selector field resets to 802.3 code
// - partner speed bits captured, reset zero
// - partner acknowledge set on every capture; next page, fault captured
// - partner pause bits; bit 11 writable
// - partner T4 bit captured
// - partner selector resets to zero
// - page select register chooses active page
`default_nettype none
module psar_regs
  import psar_pkg::*;
#(
  // arbitrary identification values
  parameter logic [REG_W-1:0] OUI_HIGH = 16'h1234,
  parameter logic [OUI_LOW_W-1:0] OUI_LOW = 6'h2a,
  parameter logic [MODEL_W-1:0] MODEL_RESET = 6'h15,
  parameter logic [REV_W-1:0] REV_RESET = 4'h3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire psar_link_t link_i,
  input wire logic lp_page_valid_i,
  input wire logic [REG_W-1:0] lp_page_i,
  output logic [REG_W-1:0] advert_o,
  output logic [PAGE_W-1:0] page_o
);

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [REG_W-1:0] merge_write(
    input logic [REG_W-1:0] old,
    input logic [REG_W-1:0] wdat,
    input logic [1:0] sel,
    input logic [REG_W-1:0] wmask
  );
    logic [REG_W-1:0] lane;
    lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    merge_write = (old & ~lane) | (wdat & lane);
  endfunction : merge_write

  function automatic logic [REG_W-1:0] status_word(
    input psar_link_t lk,
    input logic lat
  );
    logic [REG_W-1:0] w;
    w = STATUS_FIXED;
    w[ST_AN_DONE] = lk.an_complete;
    w[ST_RFAULT] = lk.remote_fault;
    w[ST_LINK] = lat;
    w[ST_JABBER] = lk.jabber;
    status_word = w;
  endfunction : status_word

  // ************************************************
  // state
  // ************************************************
  psar_state_t s_q;
  psar_state_t s_d;

  logic req;
  logic take;
  logic wr;
  logic shared_ok;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wdat;
  logic [REG_W-1:0] rdat;

  assign req = wb_cyc_i & wb_stb_i;
  assign take = req & ~s_q.ack;
  assign wr = take & wb_we_i;
  assign idx = wb_adr_i[IDX_LSB +: IDX_W];
  assign wdat = wb_dat_i[REG_W-1:0];
  // pages beyond the shared set hide this group
  assign shared_ok = (s_q.page <= PAGE_LAST_SHARED);

  // ************************************************
  // read mux
  // ************************************************
  always_comb begin
    rdat = ZERO16;
    if (wb_adr_i[WB_ADR_W-1] == 1'b0) begin
      if (idx == IDX_PAGE_SELECT) begin
        rdat = {{(REG_W-PAGE_W){1'b0}}, s_q.page};
      end else if (shared_ok) begin
        unique case (idx)
          IDX_LINK_STATUS: begin
            rdat = status_word(s_q.link, s_q.link_lat);
          end
          IDX_IDENT_HIGH: begin
            rdat = OUI_HIGH;
          end
          IDX_IDENT_LOW: begin
            rdat = {OUI_LOW, s_q.model, s_q.rev};
          end
          IDX_LOCAL_ADVERT: begin
            rdat = s_q.advert;
          end
          IDX_PARTNER_ABILITY: begin
            rdat = s_q.partner;
          end
          default: begin
            rdat = ZERO16;
          end
        endcase
      end
    end
  end

  // ************************************************
  // next state
  // ************************************************
  logic hit;
  logic rd_status;
  assign hit = (wb_adr_i[WB_ADR_W-1] == 1'b0) & shared_ok;
  assign rd_status = take & ~wb_we_i & hit & (idx == IDX_LINK_STATUS);

  always_comb begin
    s_d = s_q;
    s_d.ack = take;
    s_d.dat = take ? {{(WB_DAT_W-REG_W){1'b0}}, rdat} : s_q.dat;
    s_d.link = link_i;
    // a drop in the reading cycle still lands: reload takes live level
    if (rd_status) begin
      s_d.link_lat = link_i.link_up;
    end else begin
      s_d.link_lat = s_q.link_lat & link_i.link_up;
    end
    if (lp_page_valid_i) begin
      s_d.partner = lp_page_i & PARTNER_KEEP;
      s_d.partner[LP_ACK] = 1'b1;
    end
    if (wr && (wb_adr_i[WB_ADR_W-1] == 1'b0)) begin
      if (idx == IDX_PAGE_SELECT) begin
        if (wb_sel_i[0]) begin
          s_d.page = wb_dat_i[PAGE_W-1:0];
        end
      end else if (shared_ok) begin
        unique case (idx)
          IDX_IDENT_LOW: begin
            // only model and revision take writes
            {s_d.model, s_d.rev} = (MODEL_W+REV_W)'(merge_write(
              {OUI_LOW, s_q.model, s_q.rev}, wdat, wb_sel_i[1:0],
              IDENT_LOW_WMASK));
          end
          IDX_LOCAL_ADVERT: begin
            s_d.advert = merge_write(s_q.advert, wdat, wb_sel_i[1:0],
              ADVERT_WMASK);
          end
          IDX_PARTNER_ABILITY: begin
            if (!lp_page_valid_i) begin
              s_d.partner = merge_write(s_q.partner, wdat, wb_sel_i[1:0],
                PARTNER_WMASK);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.ack <= 1'b0;
      s_q.dat <= '0;
      s_q.page <= '0;
      s_q.link <= '0;
      s_q.link_lat <= 1'b0;
      s_q.model <= MODEL_RESET;
      s_q.rev <= REV_RESET;
      s_q.advert <= ADVERT_RESET;
      s_q.partner <= ZERO16;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign advert_o = s_q.advert;
  assign page_o = s_q.page;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_cycle_a: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o || !req)
    else $error("ack not a single cycle pulse");

  status_fixed_bits_a: assert property (
    rd_status |=> (wb_dat_o[15:6] == STATUS_FIXED[15:6])
      && wb_dat_o[3] && wb_dat_o[0])
    else $error("fixed status bits wrong");

  link_latch_low_a: assert property (
    !link_i.link_up ##1 !rd_status [*2] |=> !s_q.link_lat)
    else $error("link drop not held until read");

  an_done_follow_a: assert property (
    rd_status ##0 $past(link_i.an_complete) |=> wb_dat_o[ST_AN_DONE])
    else $error("complete bit not reported");

  page_hide_a: assert property (
    take && !shared_ok && idx != IDX_PAGE_SELECT |=> wb_dat_o == '0)
    else $error("hidden page returned data");

  advert_reserved_a: assert property (
    (advert_o & ~ADVERT_WMASK) == ZERO16)
    else $error("reserved advertisement bits set");

  partner_capture_a: assert property (
    lp_page_valid_i |=> s_q.partner[LP_ACK]
      && s_q.partner[8:5] == $past(lp_page_i[8:5]))
    else $error("partner page not captured");

  ident_high_read_a: assert property (
    take && !wb_we_i && hit && idx == IDX_IDENT_HIGH
      |=> wb_dat_o == {16'h0000, OUI_HIGH})
    else $error("identifier high wrong");

  status_ro_write_a: assert property (
    wr && hit && !lp_page_valid_i
      && (idx == IDX_LINK_STATUS || idx == IDX_IDENT_HIGH)
      |=> $stable(advert_o) && $stable({s_q.model, s_q.rev, s_q.partner}))
    else $error("read-only write disturbed state");

  // ************************************************
  // checks: register contents and write masks
  // ************************************************
  ident_low_read_a: assert property (
    take && !wb_we_i && hit && idx == IDX_IDENT_LOW
      |=> wb_dat_o[REG_W-1 -: OUI_LOW_W] == OUI_LOW)
    else $error("identifier low prefix wrong");

  advert_write_a: assert property (
    wr && hit && idx == IDX_LOCAL_ADVERT && wb_sel_i[1:0] == 2'b11
      |=> advert_o == ($past(wdat) & ADVERT_WMASK))
    else $error("advertisement write not applied");

  ident_low_write_a: assert property (
    wr && hit && idx == IDX_IDENT_LOW && wb_sel_i[1:0] == 2'b11
      |=> {s_q.model, s_q.rev} == $past(wdat[MODEL_W+REV_W-1:0]))
    else $error("model or revision write not applied");

  partner_write_a: assert property (
    wr && hit && idx == IDX_PARTNER_ABILITY && wb_sel_i[1]
      && !lp_page_valid_i
      |=> (s_q.partner & PARTNER_WMASK) == ($past(wdat) & PARTNER_WMASK)
      && (s_q.partner & ~PARTNER_WMASK)
        == ($past(s_q.partner) & ~PARTNER_WMASK))
    else $error("partner write mask broken");

  page_write_a: assert property (
    wr && !wb_adr_i[WB_ADR_W-1] && idx == IDX_PAGE_SELECT && wb_sel_i[0]
      |=> page_o == $past(wb_dat_i[PAGE_W-1:0]))
    else $error("page select write not applied");

  hidden_write_a: assert property (
    wr && !hit && idx == IDX_LOCAL_ADVERT |=> $stable(advert_o))
    else $error("hidden page write reached advertisement");

  unmapped_addr_a: assert property (
    take && wb_adr_i[WB_ADR_W-1] |=> wb_dat_o == '0)
    else $error("unmapped address returned data");

  unmapped_index_a: assert property (
    take && hit && (idx == '0
      || (idx > IDX_PARTNER_ABILITY && idx != IDX_PAGE_SELECT))
      |=> wb_dat_o == '0)
    else $error("unsupported index returned data");

  partner_reserved_a: assert property (
    (s_q.partner & ~PARTNER_KEEP & ~(REG_W'(1) << LP_ACK)) == ZERO16)
    else $error("reserved partner bit set");

  // ************************************************
  // checks: status and link
  // ************************************************
  status_link_bit_a: assert property (
    rd_status |=> wb_dat_o[ST_LINK] == $past(s_q.link_lat)
      && s_q.link_lat == $past(link_i.link_up))
    else $error("latched link bit not reported or reloaded");

  link_no_rise_a: assert property (
    !rd_status && !s_q.link_lat |=> !s_q.link_lat)
    else $error("latched link bit rose without a read");

  rfault_follow_a: assert property (
    rd_status |=> wb_dat_o[ST_RFAULT] == $past(link_i.remote_fault, 2))
    else $error("remote fault bit not reported");

  jabber_follow_a: assert property (
    rd_status |=> wb_dat_o[ST_JABBER] == $past(link_i.jabber, 2))
    else $error("jabber bit not reported");

  an_level_follow_a: assert property (
    rd_status |=> wb_dat_o[ST_AN_DONE] == $past(link_i.an_complete, 2))
    else $error("complete bit level not reported");

  // ************************************************
  // checks: reset values
  // ************************************************
  reset_advert_a: assert property (
    $fell(rst_i) |-> advert_o == ADVERT_RESET && page_o == '0)
    else $error("advertisement or page not reset");

  reset_partner_a: assert property (
    $fell(rst_i) |-> s_q.partner == ZERO16)
    else $error("partner ability not reset");

  reset_link_a: assert property (
    $fell(rst_i) |-> !s_q.link_lat && s_q.link == '0)
    else $error("link status copies not reset");

  reset_ident_a: assert property (
    $fell(rst_i) |-> s_q.model == MODEL_RESET && s_q.rev == REV_RESET)
    else $error("model or revision not reset");

endmodule : psar_regs
`default_nettype wire

// ==== hdl/psar_pkg.sv ====
// package: offsets, field layouts, reset values and state types
`default_nettype none
package psar_pkg;

  // ************************************************
  // bus and index decode
  // ************************************************
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 5'h01;
  localparam logic [IDX_W-1:0] IDX_IDENT_HIGH = 5'h02;
  localparam logic [IDX_W-1:0] IDX_IDENT_LOW = 5'h03;
  localparam logic [IDX_W-1:0] IDX_LOCAL_ADVERT = 5'h04;
  localparam logic [IDX_W-1:0] IDX_PARTNER_ABILITY = 5'h05;
  localparam logic [IDX_W-1:0] IDX_PAGE_SELECT = 5'h1f;
  localparam int unsigned PAGE_W = 8;
  localparam logic [PAGE_W-1:0] PAGE_LAST_SHARED = 8'h02;

  // ************************************************
  // link status fields
  // ************************************************
  localparam logic [REG_W-1:0] STATUS_FIXED = 16'h7909;
  localparam int unsigned ST_AN_DONE = 5;
  localparam int unsigned ST_RFAULT = 4;
  localparam int unsigned ST_LINK = 2;
  localparam int unsigned ST_JABBER = 1;

  // ************************************************
  // identifier, advertisement and partner fields
  // ************************************************
  localparam int unsigned OUI_LOW_W = 6;
  localparam int unsigned MODEL_W = 6;
  localparam int unsigned REV_W = 4;
  localparam logic [REG_W-1:0] ADVERT_RESET = 16'h01e1;
  localparam logic [REG_W-1:0] ADVERT_WMASK = 16'hadff;
  localparam logic [REG_W-1:0] IDENT_LOW_WMASK = 16'h03ff;
  localparam logic [REG_W-1:0] PARTNER_KEEP = 16'hafff;
  localparam logic [REG_W-1:0] PARTNER_WMASK = 16'h0800;
  localparam int unsigned LP_ACK = 14;
  localparam logic [REG_W-1:0] ZERO16 = 16'h0000;

  // ************************************************
  // carriers and state
  // ************************************************
  typedef struct packed {
    logic an_complete;
    logic remote_fault;
    logic link_up;
    logic jabber;
  } psar_link_t;

  typedef struct packed {
    logic ack;
    logic [WB_DAT_W-1:0] dat;
    logic [PAGE_W-1:0] page;
    psar_link_t link;
    logic link_lat;
    logic [MODEL_W-1:0] model;
    logic [REV_W-1:0] rev;
    logic [REG_W-1:0] advert;
    logic [REG_W-1:0] partner;
  } psar_state_t;

endpackage : psar_pkg
`default_nettype wire

// ==== testbench/psar_partner.sv ====
// link partner model: status levels and base page pulses
`default_nettype none
module psar_partner
  import psar_pkg::*;
(
  input wire logic clk_i,
  input wire psar_link_t link_set_i,
  input wire logic send_i,
  input wire logic [REG_W-1:0] word_i,
  output psar_link_t link_o,
  output logic valid_o,
  output logic [REG_W-1:0] page_o
);
  logic [REG_W-1:0] last_q = 16'h0000;
  // idle page line shows the inverse of the last page
  always @(posedge clk_i) begin
    link_o <= link_set_i;
    valid_o <= send_i;
    page_o <= send_i ? word_i : ~last_q;
    if (send_i) begin
      last_q <= word_i;
    end
  end
endmodule : psar_partner
`default_nettype wire

// ==== testbench/psar_regs_test.sv ====
// self-checking bench for the status, identifier and advertisement bank
`default_nettype none
module psar_regs_test
  import psar_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, send = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, lanes = 4'h3;
  logic [31:0] wdat = 32'h0;
  logic [REG_W-1:0] word = 16'h0, lw = 16'h0, pv, lpp, adv;
  psar_link_t lset = '0, lk;
  logic lpv, ack;
  logic [PAGE_W-1:0] pg;
  logic [WB_DAT_W-1:0] rdat;
  logic [31:0] exp_q[$];
  int failures = 0, checks_done = 0, seed;
  always #12.5 clk_i = ~clk_i;
  psar_partner u_lp (.clk_i(clk_i), .link_set_i(lset), .send_i(send),
    .word_i(lw), .link_o(lk), .valid_o(lpv), .page_o(lpp));
  psar_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link_i(lk),
    .lp_page_valid_i(lpv), .lp_page_i(lpp), .advert_o(adv), .page_o(pg));
  // ****************
  // tasks
  // ****************
  task automatic conclude;
    failures += exp_q.size();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    sel <= lanes;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    cyc <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (n >= 16) begin
      failures++;
      conclude();
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    bus(1'b0, a, 16'h0);
  endtask : rd
  task automatic link(input logic [3:0] v);
    @(posedge clk_i);
    lset <= psar_link_t'(v);
    repeat (3) @(posedge clk_i);
  endtask : link
  // read data checked as each read ack appears
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      cmp("read data", exp_q.pop_front(), rdat);
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    seed = $urandom(32'hd62a);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10, 16'h01e1);
    rd(8'h14, 16'h0000);
    rd(8'h08, 16'h1234);
    rd(8'h0c, {6'h2a, 6'h15, 4'h3});
    link(4'hf);
    rd(8'h04, 16'h793b);
    rd(8'h04, 16'h793f);
    link(4'h0);
    link(4'h2);
    rd(8'h04, 16'h7909);
    bus(1'b1, 8'h04, 16'h0000);
    bus(1'b1, 8'h08, 16'hedcb);
    rd(8'h08, 16'h1234);
    rd(8'h04, 16'h790d);
    word = 16'($urandom);
    bus(1'b1, 8'h10, word);
    cmp("advert_o", {16'h0, word & 16'hadff}, {16'h0, adv});
    rd(8'h10, word & 16'hadff);
    bus(1'b1, 8'h0c, word);
    rd(8'h0c, {6'h2a, word[9:0]});
    lanes <= 4'h1;
    bus(1'b1, 8'h10, 16'hffff);
    lanes <= 4'h3;
    word = (word & 16'had00) | 16'h00ff;
    rd(8'h10, word);
    pv = 16'($urandom);
    @(posedge clk_i);
    lw <= pv;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    pv = (pv & 16'hafff) | 16'h4000;
    rd(8'h14, pv);
    bus(1'b1, 8'h14, ~pv);
    rd(8'h14, pv ^ 16'h0800);
    for (int p = 1; p < 4; p++) begin
      bus(1'b1, 8'h7c, 16'(p));
      cmp("page_o", p, {24'h0, pg});
      rd(8'h04, p < 3 ? 16'h790d : 16'h0000);
    end
    bus(1'b1, 8'h10, 16'h0000);
    bus(1'b1, 8'h7c, 16'h0000);
    rd(8'h10, word & 16'hadff);
    rd(8'h18, 16'h0000);
    rd(8'h84, 16'h0000);
    bus(1'b1, 8'h7c, 16'h0001);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp("page_o", 32'h0, {24'h0, pg});
    rd(8'h10, 16'h01e1);
    rd(8'h14, 16'h0000);
    rd(8'h04, 16'h7909);
    rd(8'h0c, {6'h2a, 6'h15, 4'h3});
    repeat (2) @(posedge clk_i);
    conclude();
  end
endmodule : psar_regs_test
`default_nettype wire
